/* verilog/fpi_regs.vh */
/*
 * Constants of the fieldbus process-image command block: image byte
 * offsets, command codes, field positions, settings and reset values.
 * Assumes inclusion by its bare name from the design file and the testbench.
 */
`ifndef FPI_REGS_VH
`define FPI_REGS_VH

// read image byte offsets
`define FPI_RD_GROSS      4'h0
`define FPI_RD_NET        4'h4
`define FPI_RD_XCHG       4'h8
`define FPI_RD_STATUS     4'hc
`define FPI_RD_INSTAT     4'he
`define FPI_RD_OUTSTAT    4'hf
// write image byte offsets
`define FPI_WR_CMD        3'h0
`define FPI_WR_OUTCMD     3'h2
`define FPI_WR_XCHG       3'h4

// command codes
`define FPI_CMD_NONE      16'h0000
`define FPI_CMD_CAL_ZERO  16'h0064
`define FPI_CMD_CAL_FIRST 16'h0065
`define FPI_CMD_SMP_READ  16'h0066
`define FPI_CMD_SMP_WRITE 16'h0067
`define FPI_CMD_CAL_CANCEL 16'h0068
`define FPI_CMD_CAL_ADD   16'h006a
`define FPI_CMD_ID_SEND   16'h0078
`define FPI_CMD_PW_SEND   16'h0079
`define FPI_CMD_SEED_READ 16'h007a
`define FPI_CMD_CODE_READ 16'h007b
`define FPI_CMD_CODE_WRITE 16'h007c

// output command word fields
`define FPI_OUT_FORCE_BIT 15
`define FPI_NUM_OUTPUTS   3
`define FPI_NUM_INPUTS    2

// calibration table depth and index width
`define FPI_CAL_POINTS    8
`define FPI_CAL_IDX_W     3
`define FPI_CAL_CNT_W     4

// link rate codes
`define FPI_RATE_125      2'h0
`define FPI_RATE_250      2'h1
`define FPI_RATE_500      2'h2

// node address limits and defaults
`define FPI_ADDR_MIN      6'h01
`define FPI_ADDR_MAX      6'h3f
`define FPI_ADDR_RESET    6'h01
`define FPI_RATE_RESET    2'h0
`define FPI_SWAP_RESET    1'b0

// result codes returned by sample read
`define FPI_RES_OK        32'h00000000
`define FPI_RES_DUP       32'h00000001
`define FPI_RES_ZERO      32'h00000002
`define FPI_RES_FULL      32'h00000003
`define FPI_RES_LOCKED    32'h00000004

`endif

/* verilog/fpi_cmd.v */
/*
 * Fieldbus process-image command interpreter, slave side. Decodes the
 * 8-byte write image, builds the 16-byte read image and runs the
 * unlock and sample-weight calibration commands.
 * A command acts once, on the frame in which the command word changes
 * to a nonzero code; the exchange word of that same frame is its
 * operand. Read-type commands park their answer in the read exchange
 * word, where it stays until the next read-type command. Calibration
 * stores report a result code that the sample-read command returns.
 * The calibration table only remembers the points; fitting a curve
 * through them is left to the weighing core, which reads the count,
 * the zero reference and the real-calibration flag.
 * Assumes the link controller hands over a complete, aligned write image
 * on each wr_valid pulse in clk's domain, and samples the read image at
 * any time. Weight, status and pin levels come from the rest of the
 * instrument; the input pins are asynchronous and synchronised here.
 */
// What this block does
// - seed read gives zero once access granted
// - access starts disabled after every reset
// - calibration commands need qualified access
// - 100 captures zero reference for calibration
// - 101 stores first point, resets count to one
// - 106 appends a point, keeps others
// - at most eight calibration points
// - refuse duplicate or zero sample values
// - 102 returns zero after successful store
// - 104 reverts to theoretical, keeps zero
// - sample word is signed two's complement
// - link rate 125, 250 or 500, default 125
// - node address 1 to 63, default 1
// - byte swap yes big-endian, no little-endian
// - read image layout gross, net, exchange, status
// - write image layout command, outputs, exchange
// - weights as magnitudes, signs in status
// - status bytes mirror inputs and outputs
// - command bits drive master-controlled outputs
// - force bit gives master every output
`timescale 1ns/1ps
`default_nettype none
`include "fpi_regs.vh"

module fpi_cmd
(
    input  wire         clk,
    input  wire         nrst,
    input  wire [63:0]  wr_image,
    input  wire         wr_valid,
    output wire [127:0] rd_image,
    input  wire [31:0]  gross_mag,
    input  wire [31:0]  net_mag,
    input  wire [15:0]  weight_status,
    input  wire [31:0]  raw_weight,
    input  wire [1:0]   input_pin,
    input  wire [2:0]   local_out,
    input  wire [2:0]   master_controlled_output_mode,
    output reg  [2:0]   output_drive,
    input  wire [5:0]   cfg_node_addr,
    input  wire [1:0]   cfg_link_rate,
    input  wire         cfg_byte_order,
    input  wire         cfg_apply,
    output reg  [5:0]   node_addr,
    output reg  [1:0]   link_rate,
    output reg          byte_order_select,
    output reg          qualified_access,
    output reg          real_cal_active,
    output reg  [31:0]  cal_zero,
    output reg  [3:0]   cal_count,
    input  wire [31:0]  seed_value,
    input  wire [31:0]  expected_password
);

    // one-hot states of the unlock sequence
    // grant is the only state that opens calibration
    localparam [3:0] UL_IDLE  = 4'b0001;
    localparam [3:0] UL_IDOK  = 4'b0010;
    localparam [3:0] UL_SEED  = 4'b0100;
    localparam [3:0] UL_GRANT = 4'b1000;

    // latched write image; the exchange word is used on arrival
    reg  [15:0] cmd_q;
    reg  [15:0] outcmd_q;
    // read exchange word and command side state
    reg  [31:0] rx_q;
    reg  [31:0] code_q;
    reg  [31:0] sample_q;
    reg  [31:0] result_q;
    reg  [3:0]  ul_q;
    reg  [3:0]  ul_d;
    // input pin synchroniser
    reg  [1:0]  in_meta_q;
    reg  [1:0]  in_sync_q;
    // calibration points and their duplicate comparators
    reg  [31:0] cal_pt_q [0:7];
    reg  [7:0]  dup_hit;
    // one loop index per process, so no variable has two writers
    integer     i;
    integer     j;
    integer     k;

    // swap a word into the image byte order
    // byte 0 of each field is the low byte unless byte swap is on
    function [31:0] order32;
        input [31:0] v;
        input        big;
        begin
            order32 = big ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
        end
    endfunction

    function [15:0] order16;
        input [15:0] v;
        input        big;
        begin
            order16 = big ? {v[7:0], v[15:8]} : v;
        end
    endfunction

    // verdict of a sample store, checked in priority order; a first
    // point never meets a duplicate or a full table, so the caller
    // passes zero for those two
    function [31:0] store_code;
        input        granted;
        input [31:0] smp;
        input        dup;
        input        full;
        begin
            if (!granted)
                store_code = `FPI_RES_LOCKED;
            else if (smp == 32'h00000000)
                store_code = `FPI_RES_ZERO;
            else if (dup)
                store_code = `FPI_RES_DUP;
            else if (full)
                store_code = `FPI_RES_FULL;
            else
                store_code = `FPI_RES_OK;
        end
    endfunction

    // decode write image fields in the selected byte order
    // fixed write layout
    wire [15:0] new_cmd    = order16(wr_image[15:0], byte_order_select);
    wire [15:0] new_outcmd = order16(wr_image[31:16], byte_order_select);
    wire [31:0] new_wx     = order32(wr_image[63:32], byte_order_select);

    // a frame that repeats the code is a no-op, hence the zero that
    // the master sends between two equal commands
    // edge of a changed, nonzero command
    wire cmd_go = wr_valid && (new_cmd != cmd_q)
                  && (new_cmd != `FPI_CMD_NONE);

    // latch command and output words; the edge detector needs the
    // previous command, the output logic the standing output word
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            cmd_q    <= 16'h0000;
            outcmd_q <= 16'h0000;
        end
        else if (wr_valid)
        begin
            cmd_q    <= new_cmd;
            outcmd_q <= new_outcmd;
        end
    end

    // input pins are asynchronous, two flops before use
    // the first flop may go metastable; only the second is read
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            in_meta_q <= 2'h0;
            in_sync_q <= 2'h0;
        end
        else
        begin
            in_meta_q <= input_pin;
            in_sync_q <= in_meta_q;
        end
    end

    // output drive: master bits win when forced or in master mode
    // registered, so the pins never see a decode glitch
    always @(posedge clk)
    begin
        if (!nrst)
            output_drive <= 3'h0;
        else
            for (j = 0; j < `FPI_NUM_OUTPUTS; j = j + 1)
                if (outcmd_q[`FPI_OUT_FORCE_BIT])
                    output_drive[j] <= outcmd_q[j];
                else if (master_controlled_output_mode[j])
                    output_drive[j] <= outcmd_q[j];
                else
                    output_drive[j] <= local_out[j];
    end

    // settings are applied together, like leaving the setup menu;
    // an out-of-range address or rate is ignored, old value kept
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            node_addr         <= `FPI_ADDR_RESET;
            link_rate         <= `FPI_RATE_RESET;
            byte_order_select <= `FPI_SWAP_RESET;
        end
        else if (cfg_apply)
        begin
            if (cfg_node_addr >= `FPI_ADDR_MIN)
                node_addr <= cfg_node_addr;
            if (cfg_link_rate <= `FPI_RATE_500)
                link_rate <= cfg_link_rate;
            byte_order_select <= cfg_byte_order;
        end
    end

    // unlock sequence next state; master keeps the order of steps
    // a wrong password drops back to idle; grant is sticky until
    // reset, which stands for power-off
    always @*
    begin
        ul_d = ul_q;
        if (cmd_go)
            case (ul_q)
                UL_IDLE, UL_IDOK, UL_SEED:
                    if (new_cmd == `FPI_CMD_ID_SEND)
                        ul_d = UL_IDOK;
                    else if (new_cmd == `FPI_CMD_PW_SEND)
                        ul_d = (ul_q != UL_IDLE
                                && code_q == expected_password)
                               ? UL_GRANT : UL_IDLE;
                    else if (new_cmd == `FPI_CMD_SEED_READ
                             && ul_q == UL_IDOK)
                        ul_d = UL_SEED;
                UL_GRANT:
                    ul_d = UL_GRANT;
                default:
                    ul_d = UL_IDLE;
            endcase
    end

    // duplicate search over stored points; slots above the count hold
    // stale values from an earlier calibration and are masked off
    always @*
    begin
        for (k = 0; k < `FPI_CAL_POINTS; k = k + 1)
            dup_hit[k] = (k < cal_count) && (cal_pt_q[k] == sample_q);
    end

    // store verdicts; a full table is only possible for an added point
    wire [31:0] first_code = store_code(qualified_access, sample_q,
                                        1'b0, 1'b0);
    wire [31:0] add_code   = store_code(qualified_access, sample_q,
                                        |dup_hit,
                                        cal_count == `FPI_CAL_POINTS);

    // command execution; reset stands in for power-off
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            ul_q             <= UL_IDLE;
            qualified_access <= 1'b0;
            code_q           <= 32'h00000000;
            sample_q         <= 32'h00000000;
            result_q         <= `FPI_RES_LOCKED;
            rx_q             <= 32'h00000000;
            real_cal_active  <= 1'b0;
            cal_zero         <= 32'h00000000;
            cal_count        <= 4'h0;
            // cleared too, so a new session never sees old points
            for (i = 0; i < `FPI_CAL_POINTS; i = i + 1)
                cal_pt_q[i] <= 32'h00000000;
        end
        else
        begin
            ul_q             <= ul_d;
            qualified_access <= (ul_d == UL_GRANT);
            // commands act once, on the frame that brings a new code
            if (cmd_go)
                case (new_cmd)
                    `FPI_CMD_CODE_WRITE:
                        code_q <= new_wx;
                    `FPI_CMD_CODE_READ:
                        rx_q <= code_q;
                    `FPI_CMD_SEED_READ:
                        rx_q <= (ul_q == UL_GRANT) ? 32'h00000000
                                                   : seed_value;
                    `FPI_CMD_SMP_WRITE:
                        sample_q <= new_wx;
                    `FPI_CMD_SMP_READ:
                        rx_q <= result_q;
                    `FPI_CMD_CAL_ZERO:
                        if (qualified_access)
                            cal_zero <= raw_weight;
                    `FPI_CMD_CAL_FIRST:
                    begin
                        result_q <= first_code;
                        // older points are only hidden by the count
                        if (first_code == `FPI_RES_OK)
                        begin
                            cal_pt_q[0]     <= sample_q;
                            cal_count       <= 4'h1;
                            real_cal_active <= 1'b1;
                        end
                    end
                    `FPI_CMD_CAL_ADD:
                    begin
                        result_q <= add_code;
                        // count is below eight whenever add_code is ok
                        if (add_code == `FPI_RES_OK)
                        begin
                            cal_pt_q[cal_count[2:0]] <= sample_q;
                            cal_count       <= cal_count + 4'h1;
                            real_cal_active <= 1'b1;
                        end
                    end
                    `FPI_CMD_CAL_CANCEL:
                        if (qualified_access)
                        begin
                            cal_count       <= 4'h0;
                            real_cal_active <= 1'b0;
                        end
                    default:
                        rx_q <= rx_q;
                endcase
        end
    end

    // low bits mirror pins, rest zero
    wire [7:0] in_stat  = {6'h00, in_sync_q};
    wire [7:0] out_stat = {5'h00, output_drive};

    // read image; weights arrive as magnitudes, signs in status word
    // weights and status pass straight through so the master always
    // reads the newest measurement; only the exchange word is held
    // fixed read layout
    assign rd_image = {out_stat, in_stat,
                       order16(weight_status, byte_order_select),
                       order32(rx_q, byte_order_select),
                       order32(net_mag, byte_order_select),
                       order32(gross_mag, byte_order_select)};

endmodule
`default_nettype wire

/* dv/fpi_cmd_checker.sv */
/* port checker for the process-image command block.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module fpi_chk
(
    input wire logic         clk,
    input wire logic         nrst,
    input wire logic [63:0]  wr_image,
    input wire logic         wr_valid,
    input wire logic [127:0] rd_image,
    input wire logic [31:0]  gross_mag,
    input wire logic [2:0]   master_controlled_output_mode,
    input wire logic [2:0]   output_drive,
    input wire logic [5:0]   node_addr,
    input wire logic [1:0]   link_rate,
    input wire logic         byte_order_select,
    input wire logic         qualified_access,
    input wire logic [3:0]   cal_count
);
    // output command word as decoded under the current byte order
    wire [15:0] oc = byte_order_select ?
        {wr_image[23:16], wr_image[31:24]} : wr_image[31:16];
    wire [2:0]  oc_bits = oc[2:0];
    wire [31:0] gsw = {gross_mag[7:0], gross_mag[15:8],
                       gross_mag[23:16], gross_mag[31:24]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // a lone frame: the next cycle is idle, so the drive is unambiguous
    sequence s_force;
        wr_valid && oc[15] ##1 !wr_valid;
    endsequence
    sequence s_mode;
        wr_valid && !oc[15] ##1 !wr_valid;
    endsequence
    AST_RESET: assert property (disable iff (1'b0) !nrst
        |=> !qualified_access && node_addr == 6'h01 && link_rate == 2'h0
        && !byte_order_select) else $error("reset state wrong");
    AST_ADDR: assert property (node_addr != 6'h00)
        else $error("node address zero");
    AST_RATE: assert property (link_rate != 2'h3)
        else $error("illegal link rate");
    AST_CALMAX: assert property (cal_count <= 4'h8)
        else $error("too many points");
    AST_LOCKED: assert property (!qualified_access |=>
        $stable(cal_count)) else $error("calibration while locked");
    AST_STEP: assert property ($changed(cal_count) |->
        cal_count == $past(cal_count) + 4'h1 || cal_count <= 4'h1)
        else $error("point count jumped");
    AST_FORCE: assert property (s_force |=>
        output_drive == $past(oc_bits, 2)) else $error("force ignored");
    AST_MODE: assert property (s_mode |=>
        ((output_drive ^ $past(oc_bits, 2))
        & master_controlled_output_mode) == 3'h0)
        else $error("master output wrong");
    AST_GROSS: assert property (rd_image[31:0] ==
        (byte_order_select ? gsw : gross_mag)) else $error("gross wrong");
    AST_OUTSTAT: assert property (rd_image[127:120] ==
        {5'h00, output_drive}) else $error("output status wrong");
endmodule
bind fpi_cmd fpi_chk u_fpi_chk (.clk(clk), .nrst(nrst),
    .wr_image(wr_image), .wr_valid(wr_valid), .rd_image(rd_image),
    .gross_mag(gross_mag), .output_drive(output_drive),
    .master_controlled_output_mode(master_controlled_output_mode),
    .node_addr(node_addr), .link_rate(link_rate), .cal_count(cal_count),
    .byte_order_select(byte_order_select),
    .qualified_access(qualified_access));
`default_nettype wire

/* dv/fpi_master.sv */
/* plc-side master model writing the 8-byte image.
   assumes the bench calls put or issue; big picks byte order. */
`timescale 1ns/1ps
`default_nettype none
module fpi_master
(
    input  wire logic        clk,
    input  wire logic        big,
    output var  logic [63:0] wr_image,
    output var  logic        wr_valid
);
    initial wr_image = 64'h0;
    initial wr_valid = 1'b0;
    function automatic logic [63:0] enc(input logic [15:0] c, o,
                                        input logic [31:0] x);
        if (big)
            return {x[7:0], x[15:8], x[23:16], x[31:24],
                    o[7:0], o[15:8], c[7:0], c[15:8]};
        return {x, o, c};
    endfunction
    // one frame; data inverted afterwards so stale bytes never match
    task put(input logic [15:0] c, o, input logic [31:0] x);
        @(posedge clk);
        wr_image <= enc(c, o, x);
        wr_valid <= 1'b1;
        @(posedge clk);
        wr_image <= ~wr_image;
        wr_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task issue(input logic [15:0] c, o, input logic [31:0] x);
        put(c, o, x);
        put(16'h0000, o, x);
    endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
/* self-checking bench for fpi_cmd with the master model.
   assumes the shared constant header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "fpi_regs.vh"
module testbench;
    logic         clk, nrst, wr_valid, cfg_apply, cfg_byte_order, big;
    logic         byte_order_select, qualified_access, real_cal_active;
    logic [1:0]   input_pin, cfg_link_rate, link_rate;
    logic [2:0]   local_out, mode, output_drive;
    logic [3:0]   cal_count;
    logic [5:0]   cfg_node_addr, node_addr;
    logic [15:0]  weight_status, oc_q;
    logic [31:0]  gross_mag, net_mag, raw_weight, cal_zero, seed_value;
    logic [31:0]  expected_password;
    logic [63:0]  wr_image;
    logic [127:0] rd_image;
    int           check_count, failures, i;
    fpi_cmd u_fpi_cmd (.clk(clk), .nrst(nrst), .wr_image(wr_image),
        .wr_valid(wr_valid), .rd_image(rd_image), .gross_mag(gross_mag),
        .net_mag(net_mag), .weight_status(weight_status),
        .raw_weight(raw_weight), .input_pin(input_pin),
        .local_out(local_out), .master_controlled_output_mode(mode),
        .output_drive(output_drive), .cfg_node_addr(cfg_node_addr),
        .cfg_link_rate(cfg_link_rate), .cfg_byte_order(cfg_byte_order),
        .cfg_apply(cfg_apply), .node_addr(node_addr),
        .link_rate(link_rate), .byte_order_select(byte_order_select),
        .qualified_access(qualified_access), .cal_zero(cal_zero),
        .real_cal_active(real_cal_active), .cal_count(cal_count),
        .seed_value(seed_value), .expected_password(expected_password));
    fpi_master u_fpi_master (.clk(clk), .big(big), .wr_image(wr_image),
        .wr_valid(wr_valid));
    // 25 MHz clock
    always #20 clk = ~clk;
    task chk(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // read word at a byte offset, decoded with the expected order
    function automatic logic [31:0] rdx(input int off);
        logic [31:0] w;
        w = rd_image[8*off +: 32];
        return big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction
    task cmd(input logic [15:0] c, input logic [31:0] x);
        u_fpi_master.issue(c, oc_q, x);
        #1;
    endtask
    task unlock(input logic [31:0] pw);
        cmd(`FPI_CMD_CODE_WRITE, 32'h42);
        cmd(`FPI_CMD_ID_SEND, 32'h0);
        cmd(`FPI_CMD_SEED_READ, 32'h0);
        chk(rdx(8), seed_value);
        cmd(`FPI_CMD_CODE_WRITE, pw);
        cmd(`FPI_CMD_PW_SEND, pw);
        cmd(`FPI_CMD_SEED_READ, pw);
    endtask
    task sample(input logic [31:0] x, input logic [15:0] c,
                input logic [31:0] res);
        cmd(`FPI_CMD_SMP_WRITE, x);
        cmd(c, x);
        cmd(`FPI_CMD_SMP_READ, x);
        chk(rdx(8), res);
    endtask
    task set_cfg(input logic [5:0] a, input logic [1:0] r, input logic b);
        @(posedge clk);
        {cfg_node_addr, cfg_link_rate, cfg_byte_order} <= {a, r, b};
        cfg_apply <= 1'b1;
        @(posedge clk);
        cfg_apply <= 1'b0;
        big <= b;
        #1;
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog: the tests need well under 2000 cycles
    initial
    begin
        #200000;
        failures++;
        tally_and_finish;
    end
    initial
    begin
        {clk, nrst, cfg_apply, cfg_byte_order, big} = 5'h0;
        {input_pin, cfg_link_rate, local_out, mode} = 10'h0;
        {cfg_node_addr, oc_q, weight_status} = {6'h1, 16'h0, 16'h0880};
        {gross_mag, net_mag, raw_weight} = {32'h12345, 32'h6789, 32'h1111};
        {seed_value, expected_password} = {32'h5eed0001, 32'h0badcafe};
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(32'(qualified_access), 32'h0);
        chk(rdx(4), net_mag);
        chk(32'(rd_image[111:96]), 32'(weight_status));
        cmd(`FPI_CMD_CAL_ZERO, 32'h0);
        chk(cal_zero, 32'h0);
        sample(32'd500, `FPI_CMD_CAL_FIRST, `FPI_RES_LOCKED);
        $display("test locked done");
        unlock(~expected_password);
        chk(32'(qualified_access), 32'h0);
        unlock(expected_password);
        chk(rdx(8), 32'h0);
        $display("test unlock done");
        @(posedge clk) raw_weight <= 32'h1234;
        cmd(`FPI_CMD_CAL_ZERO, 32'h0);
        chk(cal_zero, 32'h1234);
        sample(32'hffffffc8, `FPI_CMD_CAL_FIRST, `FPI_RES_OK);
        sample(32'hffffffc8, `FPI_CMD_CAL_ADD, `FPI_RES_DUP);
        sample(32'h0, `FPI_CMD_CAL_ADD, `FPI_RES_ZERO);
        for (i = 2; i <= 8; i++)
        begin
            sample(i * 100, `FPI_CMD_CAL_ADD, `FPI_RES_OK);
            chk(32'(cal_count), i);
        end
        sample(32'd5000, `FPI_CMD_CAL_ADD, `FPI_RES_FULL);
        sample(32'd77, `FPI_CMD_CAL_FIRST, `FPI_RES_OK);
        chk(32'(cal_count), 32'h1);
        cmd(`FPI_CMD_CAL_CANCEL, 32'h0);
        chk(32'(real_cal_active), 32'h0);
        chk(cal_zero, 32'h1234);
        @(posedge clk) raw_weight <= 32'h5678;
        u_fpi_master.put(`FPI_CMD_CAL_ZERO, oc_q, 32'h0);
        raw_weight <= 32'h9abc;
        u_fpi_master.put(`FPI_CMD_CAL_ZERO, oc_q, 32'h0);
        cmd(`FPI_CMD_NONE, 32'h0);
        chk(cal_zero, 32'h5678);
        $display("test calibration done");
        @(posedge clk) {mode, local_out, input_pin} <= 8'b001_010_10;
        oc_q = 16'h0005;
        cmd(`FPI_CMD_NONE, 32'h0);
        chk(32'(output_drive), 32'h3);
        chk(32'(rd_image[119:112]), 32'h2);
        oc_q = 16'h8006;
        cmd(`FPI_CMD_NONE, 32'h0);
        chk(32'(output_drive), 32'h6);
        $display("test outputs done");
        for (i = 0; i < 4; i++)
        begin
            set_cfg(i == 3 ? 6'h0 : 6'(63 - i), 2'(i), 1'b1);
            chk(32'(node_addr), i == 3 ? 61 : 63 - i);
            chk(32'(link_rate), i == 3 ? 2 : i);
        end
        chk(rdx(0), gross_mag);
        cmd(`FPI_CMD_CODE_WRITE, 32'h0a0b0c0d);
        cmd(`FPI_CMD_CODE_READ, 32'h0);
        chk(rdx(8), 32'h0a0b0c0d);
        $display("test settings done");
        @(posedge clk) {nrst, big} <= 2'b00;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk({qualified_access, 25'h0, node_addr}, 32'h1);
        cmd(`FPI_CMD_SEED_READ, 32'h0);
        chk(rdx(8), seed_value);
        $display("test power cycle done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
